// File: inc/csc_pkg.sv
// Shared constants, field layouts and types of the CPU status and cycle count block.
package csc_pkg;

    // -------------------------------------------------------------------------
    // Control word layout and reset
    // -------------------------------------------------------------------------
    localparam logic [31:0] CSC_PROGRAM_CONTROL_WORD_RESET = 32'h0000_0800;
    // Undefined fields are held at zero so they can never be modified.
    localparam logic [31:0] CSC_PROGRAM_CONTROL_WORD_WMASK = 32'h00ff_ffff;

    // Floating-point exception flags, one bit each.
    typedef struct packed {
        logic fp_invalid_flag;
        logic ovf;
        logic unf;
        logic fp_inexact_flag;
        logic fp_divzero_flag;
        logic fp_result_flushed_flag;
        logic fp_operand_flushed_flag;
    } csc_fpx_s;

    typedef struct packed {
        logic [7:0] rsvd;        // Bits 31:24, read as zero.
        logic       trap_first_exit;         // Bit 23, trap on first exit.
        logic       writeback_overflow_trap_en;      // Bit 22.
        logic       writeback_overflow_flag;         // Bit 21.
        logic       misaligned_store_trap_en;      // Bit 20.
        logic       misaligned_store_flag;         // Bit 19.
        csc_fpx_s   trap_en;     // Bits 18:12.
        logic       cs;          // Bit 11, count all cycles.
        csc_fpx_s   flags;       // Bits 10:4.
        logic       byte_order_select;         // Bit 3, 1 selects big endian.
        logic       interrupt_mask_enable;         // Bit 2.
        logic [1:0] rnd;         // Bits 1:0.
    } csc_program_control_word_s;

    // -------------------------------------------------------------------------
    // Rounding modes, access sizes, counter read selects
    // -------------------------------------------------------------------------
    localparam logic [1:0] CSC_RND_NEAREST = 2'h0;
    localparam logic [1:0] CSC_RND_ZERO    = 2'h1;
    localparam logic [1:0] CSC_RND_POSINF  = 2'h2;
    localparam logic [1:0] CSC_RND_NEGINF  = 2'h3;

    typedef enum logic [1:0] {
        CSC_SZ_8,
        CSC_SZ_16,
        CSC_SZ_32
    } csc_size_e;

    typedef enum logic [1:0] {
        CSC_CNT_SLAVE_LO,
        CSC_CNT_SLAVE_HI,
        CSC_CNT_MASTER_LO
    } csc_cnt_sel_e;

    localparam logic [31:0] CSC_ALIGN16_MASK = 32'hffff_fffe;
    localparam logic [31:0] CSC_ALIGN32_MASK = 32'hffff_fffc;
    localparam logic [3:0]  CSC_WB_LIMIT     = 4'h5;
    localparam logic [63:0] CSC_CNT_ONE      = 64'h0000_0000_0000_0001;
    localparam logic [31:0] CSC_BOOL_TRUE    = 32'h0000_0001;
    localparam logic [31:0] CSC_BOOL_FALSE   = 32'h0000_0000;

    // Memory access request seen by the alignment logic.
    typedef struct packed {
        logic        valid;
        logic        store;
        csc_size_e   size;
        logic [31:0] addr;
    } csc_mem_s;

    // Interruptible jump event.
    typedef struct packed {
        logic        valid;
        logic        interrupted;
        logic [31:0] target;
    } csc_jump_s;

endpackage : csc_pkg

// File: src/csc_cycle_ctr.sv
// Master cycle counter with a slave snapshot register.
module csc_cycle_ctr
    import csc_pkg::*;
(
    input  wire logic        clk_sys,    // CPU clock.
    input  wire logic        arst_n,     // Asynchronous reset, active low.
    input  wire logic        inc_en,     // Count this cycle.
    input  wire logic        snap,       // Copy master into slave.
    output logic      [63:0] master_reg, // Running master count.
    output logic      [63:0] slave_reg   // Snapshot for coherent reads.
);

    // -------------------------------------------------------------------------
    // Counter and snapshot
    // -------------------------------------------------------------------------
    // Master runs on the enable supplied by the mode logic.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            master_reg <= '0;
        end else if (inc_en) begin
            master_reg <= master_reg + CSC_CNT_ONE;
        end
    end

    // Slave holds a coherent 64-bit value between good jumps.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slave_reg <= '0;
        end else if (snap) begin
            slave_reg <= master_reg;
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_cnt_step;
        ##1 1 |-> master_reg == $past(master_reg) + ($past(inc_en) ? CSC_CNT_ONE : '0);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("master count step wrong");

    property p_slave_hold;
        !snap |=> $stable(slave_reg);
    endproperty
    a_slave_hold: assert property (p_slave_hold) else $error("slave changed without jump");

endmodule : csc_cycle_ctr

// File: src/csc_status_unit.sv
// Program control word, jump program counters, cycle counter and boolean helpers.
module csc_status_unit
    import csc_pkg::*;
(
    input  wire logic         clk_sys,         // CPU clock, 40 MHz.
    input  wire logic         arst_n,          // Asynchronous reset, active low.
    // Software access to the special registers.
    input  wire logic         program_control_word_wr,         // Control word write strobe.
    input  wire logic  [31:0] program_control_word_wdata,      // Control word write data.
    input  wire logic         dpc_wr,          // Jump target pc write strobe.
    input  wire logic         spc_wr,          // Tree start pc write strobe.
    input  wire logic  [31:0] pc_wdata,        // Data for either pc write.
    output logic       [31:0] program_control_word_rdata,      // Control word read value.
    output logic       [31:0] jump_target_pc,  // Return address register.
    output logic       [31:0] tree_start_pc,   // Decision tree start register.
    input  csc_cnt_sel_e      cnt_sel,         // Counter read select.
    output logic       [31:0] cnt_rdata,       // Counter read value.
    // Floating point.
    input  wire logic         fp_valid,        // FP operation completes.
    input  csc_fpx_s          fp_exc,          // Exceptions it incurred.
    input  wire logic         fp_fixed_rz,     // Conversion using fixed rounding.
    output logic       [1:0]  fp_round_mode,   // Rounding for this operation.
    // Memory alignment.
    input  csc_mem_s          mem_req,         // Load or store request.
    output logic       [31:0] mem_addr_out,    // Aligned access address.
    output logic              mem_out_valid,   // Aligned access valid.
    output logic              big_endian,      // Byte order for loads and stores.
    // Pipeline events.
    input  wire logic  [3:0]  wb_count,        // Results written back this cycle.
    input  wire logic         stall,           // Pipeline stalled this cycle.
    input  csc_jump_s         jump,            // Interruptible jump.
    // Interrupts and exceptions.
    input  wire logic         int_req,         // Maskable interrupt source.
    input  wire logic         nmi_req,         // Non-maskable interrupt.
    output logic              int_pass,        // Maskable interrupt to dispatch.
    output logic              nmi_pass,        // NMI to dispatch.
    output logic              exc_req,         // Exception request.
    // Booleans and guards.
    input  wire logic  [31:0] guard_word,      // Register used as guard.
    output logic              guard_true,      // Guard judged by its LSB.
    input  wire logic         bool_in,         // Boolean operation result.
    output logic       [31:0] bool_word        // Encoded boolean result.
);

    // -------------------------------------------------------------------------
    // Control word state
    // -------------------------------------------------------------------------
    csc_program_control_word_s   program_control_word_reg;
    csc_program_control_word_s   program_control_word_next;
    logic        mis_store;
    logic        wb_over;
    logic        fp_exc_req;
    logic        mse_req;
    logic        wbe_req;
    logic        tfe_req;
    logic        good_jump;
    logic [63:0] master_cnt;
    logic [63:0] slave_cnt;

    assign program_control_word_rdata = program_control_word_reg;

    // Misalignment is only meaningful for halfword and word accesses.
    assign mis_store = mem_req.valid && mem_req.store &&
                       (((mem_req.size == CSC_SZ_16) && mem_req.addr[0]) ||
                        ((mem_req.size == CSC_SZ_32) && (mem_req.addr[1:0] != 2'h0)));

    assign wb_over = (wb_count > CSC_WB_LIMIT);

    // Software value first, then hardware sets overlay it so an event
    // in the write cycle is never lost.
    always_comb begin
        program_control_word_next = program_control_word_reg;
        if (program_control_word_wr) begin
            program_control_word_next = csc_program_control_word_s'(program_control_word_wdata & CSC_PROGRAM_CONTROL_WORD_WMASK);
        end
        if (fp_valid) begin
            program_control_word_next.flags = program_control_word_next.flags | fp_exc;
        end
        if (mis_store) begin
            program_control_word_next.misaligned_store_flag = 1'b1;
        end
        if (wb_over) begin
            program_control_word_next.writeback_overflow_flag = 1'b1;
        end
    end

    // The trap-on-first-exit bit is touched by software writes only.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            program_control_word_reg <= csc_program_control_word_s'(CSC_PROGRAM_CONTROL_WORD_RESET);
        end else begin
            program_control_word_reg <= program_control_word_next;
        end
    end

    // -------------------------------------------------------------------------
    // Exception requests and interrupt masking
    // -------------------------------------------------------------------------
    // Loads never feed the misalignment flag since they may be speculative.
    assign fp_exc_req = |(program_control_word_reg.flags & program_control_word_reg.trap_en);
    assign mse_req    = program_control_word_reg.misaligned_store_flag && program_control_word_reg.misaligned_store_trap_en;
    assign wbe_req    = program_control_word_reg.writeback_overflow_flag && program_control_word_reg.writeback_overflow_trap_en;
    assign tfe_req    = program_control_word_reg.trap_first_exit && jump.valid;
    assign exc_req    = fp_exc_req || mse_req || wbe_req || tfe_req;

    // NMI bypasses the mask entirely.
    assign int_pass = int_req && program_control_word_reg.interrupt_mask_enable;
    assign nmi_pass = nmi_req;

    // -------------------------------------------------------------------------
    // Rounding and byte order
    // -------------------------------------------------------------------------
    // Conversions that use fixed rounding always truncate toward zero.
    assign fp_round_mode = fp_fixed_rz ? CSC_RND_ZERO : program_control_word_reg.rnd;
    assign big_endian    = program_control_word_reg.byte_order_select;

    // -------------------------------------------------------------------------
    // Address alignment
    // -------------------------------------------------------------------------
    // Low bits are dropped for both loads and stores; the access proceeds.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_addr_out  <= '0;
            mem_out_valid <= 1'b0;
        end else begin
            mem_out_valid <= mem_req.valid;
            if (mem_req.size == CSC_SZ_32) begin
                mem_addr_out <= mem_req.addr & CSC_ALIGN32_MASK;
            end else if (mem_req.size == CSC_SZ_16) begin
                mem_addr_out <= mem_req.addr & CSC_ALIGN16_MASK;
            end else begin
                mem_addr_out <= mem_req.addr;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Jump program counters
    // -------------------------------------------------------------------------
    assign good_jump = jump.valid && !jump.interrupted;

    // Software writes take precedence over the jump update.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            jump_target_pc <= '0;
        end else if (dpc_wr) begin
            jump_target_pc <= pc_wdata;
        end else if (jump.valid) begin
            jump_target_pc <= jump.target;
        end
    end

    // An interrupted jump keeps the start of the tree that was running.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tree_start_pc <= '0;
        end else if (spc_wr) begin
            tree_start_pc <= pc_wdata;
        end else if (good_jump) begin
            tree_start_pc <= jump.target;
        end
    end

    // -------------------------------------------------------------------------
    // Cycle counter
    // -------------------------------------------------------------------------
    csc_cycle_ctr u_ctr (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .inc_en     (program_control_word_reg.cs || !stall),
        .snap       (good_jump),
        .master_reg (master_cnt),
        .slave_reg  (slave_cnt)
    );

    // Reads are registered; the slave pair stays coherent until the next uninterrupted jump.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_rdata <= '0;
        end else begin
            case (cnt_sel)
                CSC_CNT_SLAVE_LO:  cnt_rdata <= slave_cnt[31:0];
                CSC_CNT_SLAVE_HI:  cnt_rdata <= slave_cnt[63:32];
                CSC_CNT_MASTER_LO: cnt_rdata <= master_cnt[31:0];
                default:           cnt_rdata <= '0;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Boolean encoding and guards
    // -------------------------------------------------------------------------
    assign guard_true = guard_word[0];

    // Upper bits are always zero so results can be reused as guards.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bool_word <= CSC_BOOL_FALSE;
        end else begin
            bool_word <= bool_in ? CSC_BOOL_TRUE : CSC_BOOL_FALSE;
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_reset_val;
        $rose(arst_n) |-> program_control_word_rdata == CSC_PROGRAM_CONTROL_WORD_RESET;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad control word reset");

    property p_flag_sticky;
        !program_control_word_wr |=> (program_control_word_reg.flags & $past(program_control_word_reg.flags)) == $past(program_control_word_reg.flags);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("FP flag lost");

    property p_flag_set;
        fp_valid |=> (program_control_word_reg.flags & $past(fp_exc)) == $past(fp_exc);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("FP flag not set");

    property p_fp_trap;
        (program_control_word_reg.flags & program_control_word_reg.trap_en) != 7'h00 |-> exc_req;
    endproperty
    a_fp_trap: assert property (p_fp_trap) else $error("FP trap missing");

    property p_int_mask;
        !program_control_word_reg.interrupt_mask_enable |-> !int_pass && (nmi_pass == nmi_req);
    endproperty
    a_int_mask: assert property (p_int_mask) else $error("mask misapplied");

    property p_mse_set;
        mem_req.valid && mem_req.store && mem_req.size == CSC_SZ_32 && mem_req.addr[1:0] != 2'h0
            |=> program_control_word_reg.misaligned_store_flag ##0 (mem_addr_out[1:0] == 2'h0);
    endproperty
    a_mse_set: assert property (p_mse_set) else $error("misaligned store missed");

    property p_load_quiet;
        mem_req.valid && !mem_req.store && !program_control_word_reg.misaligned_store_flag && !program_control_word_wr |=> !program_control_word_reg.misaligned_store_flag;
    endproperty
    a_load_quiet: assert property (p_load_quiet) else $error("load raised misalign");

    property p_wbe;
        wb_count > CSC_WB_LIMIT |=> program_control_word_reg.writeback_overflow_flag ##0 (exc_req || !program_control_word_reg.writeback_overflow_trap_en);
    endproperty
    a_wbe: assert property (p_wbe) else $error("writeback overflow missed");

    property p_tfe;
        (program_control_word_reg.trap_first_exit && jump.valid |-> exc_req) and
        (!program_control_word_wr |=> program_control_word_reg.trap_first_exit == $past(program_control_word_reg.trap_first_exit));
    endproperty
    a_tfe: assert property (p_tfe) else $error("first exit trap wrong");

    property p_dpc;
        jump.valid && !dpc_wr |=> jump_target_pc == $past(jump.target);
    endproperty
    a_dpc: assert property (p_dpc) else $error("jump target pc not loaded");

    property p_spc_hold;
        jump.valid && jump.interrupted && !spc_wr |=> $stable(tree_start_pc);
    endproperty
    a_spc_hold: assert property (p_spc_hold) else $error("tree pc moved");

    property p_sw_wins;
        dpc_wr && jump.valid |=> jump_target_pc == $past(pc_wdata);
    endproperty
    a_sw_wins: assert property (p_sw_wins) else $error("software write lost");

    property p_slave_rd;
        cnt_sel == CSC_CNT_SLAVE_HI |=> cnt_rdata == $past(slave_cnt[63:32]);
    endproperty
    a_slave_rd: assert property (p_slave_rd) else $error("slave high read wrong");

    property p_bool;
        ##1 1 |-> bool_word == ($past(bool_in) ? CSC_BOOL_TRUE : CSC_BOOL_FALSE);
    endproperty
    a_bool: assert property (p_bool) else $error("boolean encoding wrong");

    c_good_jump: cover property (good_jump ##1 cnt_sel == CSC_CNT_SLAVE_LO);
    c_mis_store: cover property (mis_store && program_control_word_wr);
    c_fp_trap:   cover property (fp_valid ##1 exc_req);

endmodule : csc_status_unit

// File: tb/tb_top.sv
// Self-checking testbench of the CPU status and cycle count block.
module tb_top
    import csc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, arst_n, program_control_word_wr, dpc_wr, spc_wr, fp_valid, fp_fixed_rz, stall;
    logic int_req, nmi_req, bool_in;
    logic [31:0] program_control_word_wdata, pc_wdata, program_control_word_rdata, jump_target_pc, tree_start_pc;
    logic [31:0] cnt_rdata, mem_addr_out, guard_word, bool_word, acc, base;
    logic [3:0]  wb_count;
    logic [1:0]  fp_round_mode;
    logic        mem_out_valid, big_endian, int_pass, nmi_pass, exc_req, guard_true;
    csc_cnt_sel_e cnt_sel;
    csc_fpx_s     fp_exc;
    csc_mem_s     mem_req;
    csc_jump_s    jump;
    int           error_cnt, checks_done;

    csc_status_unit uut (
        .clk_sys(clk_sys), .arst_n(arst_n), .program_control_word_wr(program_control_word_wr), .program_control_word_wdata(program_control_word_wdata),
        .dpc_wr(dpc_wr), .spc_wr(spc_wr), .pc_wdata(pc_wdata), .program_control_word_rdata(program_control_word_rdata),
        .jump_target_pc(jump_target_pc), .tree_start_pc(tree_start_pc),
        .cnt_sel(cnt_sel), .cnt_rdata(cnt_rdata), .fp_valid(fp_valid), .fp_exc(fp_exc),
        .fp_fixed_rz(fp_fixed_rz), .fp_round_mode(fp_round_mode), .mem_req(mem_req),
        .mem_addr_out(mem_addr_out), .mem_out_valid(mem_out_valid),
        .big_endian(big_endian), .wb_count(wb_count), .stall(stall), .jump(jump),
        .int_req(int_req), .nmi_req(nmi_req), .int_pass(int_pass), .nmi_pass(nmi_pass),
        .exc_req(exc_req), .guard_word(guard_word), .guard_true(guard_true),
        .bool_in(bool_in), .bool_word(bool_word)
    );

    // 40 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // -------------------------------------------------------------------------
    // Access tasks
    // -------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    // The trailing idle cycle keeps two writes from touching the strobe in one step.
    task automatic program_control_word_write(input logic [31:0] w);
        program_control_word_wr    = 1'b1;
        program_control_word_wdata = w;
        tick(1);
        program_control_word_wr = 1'b0;
        tick(1);
    endtask : program_control_word_write

    task automatic mem_op(input logic st, input csc_size_e sz, input logic [31:0] a,
                          input logic [31:0] ea, input logic [31:0] ep);
        mem_req = '{valid: 1'b1, store: st, size: sz, addr: a};
        tick(1);
        mem_req = '0;
        chk({31'h0, mem_out_valid}, 32'h1);
        chk(mem_addr_out, ea);
        chk(program_control_word_rdata, ep);
        tick(1);
    endtask : mem_op

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // -------------------------------------------------------------------------
    // Main sequence, inputs change at the falling edge
    // -------------------------------------------------------------------------
    initial begin
        {arst_n, program_control_word_wr, dpc_wr, spc_wr, fp_valid, fp_fixed_rz, stall} = '0;
        {int_req, nmi_req, bool_in, program_control_word_wdata, pc_wdata, guard_word, wb_count} = '0;
        cnt_sel = CSC_CNT_MASTER_LO;
        fp_exc  = '0;
        mem_req = '0;
        jump    = '0;
        error_cnt   = 0;
        checks_done = 0;
        tick(6);
        arst_n = 1'b1;
        tick(1);
        chk(program_control_word_rdata, 32'h0000_0800);
        for (int r = 0; r < 4; r++) begin
            program_control_word_write(32'h0000_0800 | 32'(r));
            chk({30'h0, fp_round_mode}, 32'(r));
            fp_fixed_rz = 1'b1;
            #1 chk({30'h0, fp_round_mode}, {30'h0, CSC_RND_ZERO});
            tick(1);
            fp_fixed_rz = 1'b0;
        end
        program_control_word_write(32'hff00_0808);
        chk(program_control_word_rdata, 32'h0000_0808);
        chk({31'h0, big_endian}, 32'h1);
        int_req = 1'b1;
        nmi_req = 1'b1;
        #1 chk({30'h0, int_pass, nmi_pass}, 32'h1);
        program_control_word_write(32'h0000_0804);
        chk({29'h0, big_endian, int_pass, nmi_pass}, 32'h3);
        // Every flag is raised alone and must stay while the others arrive.
        acc = 32'h0000_0800;
        for (int i = 0; i < 7; i++) begin
            fp_valid = 1'b1;
            fp_exc   = csc_fpx_s'(7'h01 << i);
            tick(1);
            fp_valid = 1'b0;
            fp_exc   = '0;
            acc      = acc | (32'h10 << i);
            tick(1);
            chk(program_control_word_rdata, acc | 32'h4);
            chk({31'h0, exc_req}, 32'h0);
        end
        program_control_word_write(32'h0000_1800);
        chk(program_control_word_rdata, 32'h0000_1800);
        fp_valid = 1'b1;
        fp_exc   = '{fp_operand_flushed_flag: 1'b1, default: 1'b0};
        tick(1);
        fp_valid = 1'b0;
        fp_exc   = '0;
        chk({31'h0, exc_req}, 32'h1);
        // A software clear and a flag set in the same cycle.
        program_control_word_wr    = 1'b1;
        program_control_word_wdata = 32'h0000_0800;
        fp_valid   = 1'b1;
        fp_exc     = '{fp_invalid_flag: 1'b1, default: 1'b0};
        tick(1);
        {program_control_word_wr, fp_valid} = '0;
        fp_exc = '0;
        chk(program_control_word_rdata, 32'h0000_0c00);
        program_control_word_write(32'h0010_0800);
        mem_op(1'b0, CSC_SZ_32, 32'h0000_1003, 32'h0000_1000, 32'h0010_0800);
        mem_op(1'b1, CSC_SZ_16, 32'h0000_2002, 32'h0000_2002, 32'h0010_0800);
        mem_op(1'b1, CSC_SZ_32, 32'h0000_2006, 32'h0000_2004, 32'h0018_0800);
        chk({31'h0, exc_req}, 32'h1);
        program_control_word_write(32'h0000_0800);
        mem_op(1'b1, CSC_SZ_16, 32'h0000_3001, 32'h0000_3000, 32'h0008_0800);
        chk({31'h0, exc_req}, 32'h0);
        for (int t = 0; t < 2; t++) begin
            program_control_word_write(t ? 32'h0040_0800 : 32'h0000_0800);
            wb_count = 4'h5;
            tick(1);
            chk(program_control_word_rdata, t ? 32'h0040_0800 : 32'h0000_0800);
            wb_count = 4'h6;
            tick(1);
            wb_count = 4'h0;
            chk({31'h0, exc_req}, 32'(t));
        end
        program_control_word_write(32'h0080_0800);
        chk({31'h0, exc_req}, 32'h0);
        jump = '{valid: 1'b1, interrupted: 1'b0, target: 32'h0000_4000};
        #1 chk({31'h0, exc_req}, 32'h1);
        tick(1);
        jump = '{valid: 1'b1, interrupted: 1'b1, target: 32'h0000_5000};
        chk(tree_start_pc, 32'h0000_4000);
        tick(1);
        jump = '{valid: 1'b1, interrupted: 1'b0, target: 32'h0000_6000};
        {dpc_wr, spc_wr, pc_wdata} = {2'b11, 32'h7777_0000};
        chk(jump_target_pc, 32'h0000_5000);
        chk(tree_start_pc, 32'h0000_4000);
        chk(program_control_word_rdata, 32'h0080_0800);
        tick(1);
        {dpc_wr, spc_wr} = '0;
        jump = '0;
        chk(jump_target_pc, 32'h7777_0000);
        chk(tree_start_pc, 32'h7777_0000);
        // Counting during stalls, with and without the count-all bit.
        program_control_word_write(32'h0000_0800);
        stall = 1'b1;
        tick(2);
        base = cnt_rdata;
        tick(10);
        chk(cnt_rdata, base + 32'd10);
        program_control_word_write(32'h0000_0000);
        base = cnt_rdata;
        tick(10);
        chk(cnt_rdata, base);
        jump = '{valid: 1'b1, interrupted: 1'b0, target: 32'h0000_8000};
        tick(1);
        jump    = '0;
        stall   = 1'b0;
        cnt_sel = CSC_CNT_SLAVE_LO;
        tick(1);
        jump = '{valid: 1'b1, interrupted: 1'b1, target: 32'h0000_9000};
        tick(1);
        jump = '0;
        tick(3);
        chk(cnt_rdata, base);
        cnt_sel = CSC_CNT_SLAVE_HI;
        tick(2);
        chk(cnt_rdata, 32'h0);
        guard_word = 32'hffff_fffe;
        #1 chk({31'h0, guard_true}, 32'h0);
        guard_word = 32'h0000_0001;
        bool_in    = 1'b1;
        #1 chk({31'h0, guard_true}, 32'h1);
        tick(1);
        bool_in = 1'b0;
        chk(bool_word, CSC_BOOL_TRUE);
        tick(1);
        chk(bool_word, CSC_BOOL_FALSE);
        give_verdict();
    end

endmodule : tb_top
